// *** urfr_top.sv ***
// Serial receiver with oversampled bit recovery, frame error and address filtering.
//
// The implementer's own choices: the plain strobed port and the address map.
module urfr_top
	import urfr_pkg::*;
(
	input wire logic clk_sys_in, // 20 MHz system clock
	input wire logic rst_b_in, // asynchronous reset, active low
	input wire logic rxd_in, // serial receive pin
	input wire logic [3:0] addr_in, // register byte address
	input wire logic [31:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	input wire logic [15:0] baud_divisor_in, // system clocks per sample tick, minus one
	output logic [31:0] rdata_out, // read data, one cycle after read strobe
	output logic [2:0] char_size_field_out // shared character size for the transmitter
);
	// ---------------------------------------------------------------
	// Pin synchroniser and sample tick
	// ---------------------------------------------------------------
	logic [2:0] sync_q, sync_d;
	logic rx_q, rx_d;
	logic [15:0] div_q, div_d;
	logic tick_q, tick_d;

	always_comb begin
		sync_d = {sync_q[1:0], rxd_in};
		rx_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : rx_q;
		// An exact divisor keeps this end's share of the rate error small.
		tick_d = (div_q == 16'h0000);
		div_d = tick_d ? baud_divisor_in : div_q - 16'h0001;
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_q <= 3'h7;
			rx_q <= 1'b1;
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			rx_q <= rx_d;
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d;
	logic rx_en, dbl, mpcm, par_en, par_odd;
	logic [2:0] size;
	logic [3:0] nbits;

	assign rx_en = ctrl_q[CTRL_RX_EN_BIT];
	assign dbl = ctrl_q[CTRL_DOUBLE_BIT];
	assign mpcm = ctrl_q[CTRL_MPCM_BIT];
	assign size = ctrl_q[CTRL_SIZE_LSB +: 3];
	assign par_en = ctrl_q[CTRL_PAR_EN_BIT];
	assign par_odd = ctrl_q[CTRL_PAR_ODD_BIT];

	// Codes 0..3 give 5..8 data bits; 7 gives nine; others are taken as eight.
	function automatic logic [3:0] data_bits(input logic [2:0] code);
		if (code == SIZE_NINE) begin
			return 4'h9;
		end else if (code[2]) begin
			return 4'h8;
		end
		return {2'b00, code[1:0]} + 4'h5;
	endfunction

	// Data plus parity totals 5 to 10 bits.
	assign nbits = data_bits(size) + {3'b000, par_en};

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_in && addr_in == ADDR_CTRL) begin
			ctrl_d = wdata_in & 32'h0000_0377;
		end
	end

	// ---------------------------------------------------------------
	// Frame recovery state machine
	// ---------------------------------------------------------------
	urfr_state_t st_q, st_d;
	logic [4:0] smp_q, smp_d;
	logic [3:0] bit_q, bit_d;
	logic [9:0] shf_q, shf_d;
	logic [2:0] vote_q, vote_d;
	logic done;
	logic [9:0] frame_bits;
	logic stop_bit;
	logic [4:0] spb, first, mid, last;

	// Majority of three centre samples.
	function automatic logic maj3(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	always_comb begin
		spb = dbl ? SPB_DOUBLE : SPB_NORMAL;
		first = dbl ? FIRST_DOUBLE : FIRST_NORMAL;
		mid = dbl ? MID_DOUBLE : MID_NORMAL;
		last = dbl ? LAST_DOUBLE : LAST_NORMAL;
	end

	always_comb begin
		st_d = st_q;
		smp_d = smp_q;
		bit_d = bit_q;
		shf_d = shf_q;
		vote_d = vote_q;
		done = 1'b0;
		stop_bit = 1'b1;
		if (!rx_en) begin
			st_d = URFR_IDLE;
		end else if (tick_q) begin
			unique case (st_q)
				URFR_IDLE: begin
					if (!rx_q) begin
						st_d = URFR_START;
						smp_d = 5'h02;
						vote_d = 3'h0;
					end
				end
				URFR_START, URFR_BITS: begin
					if (smp_q == first || smp_q == mid || smp_q == last) begin
						vote_d = {vote_q[1:0], rx_q};
					end
					smp_d = smp_q + 5'h01;
					if (smp_q == last && st_q == URFR_START && maj3({vote_q[1:0], rx_q})) begin
						st_d = URFR_IDLE;
					end else if (smp_q == spb) begin
						smp_d = 5'h01;
						if (st_q == URFR_START) begin
							st_d = URFR_BITS;
							bit_d = 4'h0;
						end else begin
							shf_d = {maj3(vote_q), shf_q[9:1]};
							bit_d = bit_q + 4'h1;
							if (bit_q + 4'h1 == nbits) begin
								st_d = URFR_STOP;
							end
						end
					end
				end
				URFR_STOP: begin
					// Only the first stop bit is looked at.
					if (smp_q == first || smp_q == mid || smp_q == last) begin
						vote_d = {vote_q[1:0], rx_q};
					end
					smp_d = smp_q + 5'h01;
					if (smp_q == last) begin
						done = 1'b1;
						stop_bit = maj3({vote_q[1:0], rx_q});
						// Normal speed returns to start search at once.
						if (!dbl) begin
							st_d = URFR_IDLE;
						end
					end else if (dbl && smp_q == REARM_DOUBLE - 5'h01) begin
						// Double speed holds off start search later in the stop bit.
						st_d = URFR_IDLE;
					end
				end
			endcase
		end
	end

	// Realign the data bits so the first received bit lands at bit 0.
	assign frame_bits = shf_q >> (4'hA - nbits);

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= URFR_IDLE;
			smp_q <= 5'h00;
			bit_q <= 4'h0;
			shf_q <= 10'h000;
			vote_q <= 3'h0;
			ctrl_q <= CTRL_RESET;
		end else begin
			st_q <= st_d;
			smp_q <= smp_d;
			bit_q <= bit_d;
			shf_q <= shf_d;
			vote_q <= vote_d;
			ctrl_q <= ctrl_d;
		end
	end

	// ---------------------------------------------------------------
	// Classification, receive buffer and read port
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] buf_q, buf_d;
	logic ferr_q, ferr_d, perr_q, perr_d, ovr_q, ovr_d, avail_q, avail_d;
	logic [31:0] rdata_q, rdata_d;
	logic [2:0] size_q;
	logic [DATA_W-1:0] word;
	logic ftype, accept, par_calc, par_bit, rd_data;

	always_comb begin
		word = frame_bits[DATA_W-1:0];
		if (size != SIZE_NINE) begin
			word[8] = 1'b0;
		end
		unique case (data_bits(size))
			4'h5: word[8:5] = 4'h0;
			4'h6: word[8:6] = 3'h0;
			4'h7: word[8:7] = 2'h0;
			default: ;
		endcase
		par_bit = frame_bits[data_bits(size)];
		par_calc = ^word ^ par_odd;
		// Ninth bit for nine-bit characters, else first stop bit.
		ftype = (size == SIZE_NINE) ? frame_bits[8] : stop_bit;
		// Type one is an address; data frames are dropped under the filter.
		accept = done && (!mpcm || ftype);
		rd_data = rd_in && addr_in == ADDR_DATA;
		buf_d = buf_q;
		ferr_d = ferr_q;
		perr_d = perr_q;
		ovr_d = ovr_q;
		avail_d = avail_q;
		if (rd_data) begin
			avail_d = 1'b0;
			ovr_d = 1'b0;
		end
		if (accept) begin
			if (avail_q && !rd_data) begin
				ovr_d = 1'b1;
			end else begin
				buf_d = word;
				ferr_d = !stop_bit;
				perr_d = par_en && (par_calc != par_bit);
				avail_d = 1'b1;
			end
		end
		if (!rx_en) begin
			avail_d = 1'b0;
			ferr_d = 1'b0;
			perr_d = 1'b0;
			ovr_d = 1'b0;
		end
		rdata_d = 32'h0000_0000;
		if (rd_in) begin
			unique case (addr_in)
				ADDR_CTRL: rdata_d = ctrl_q;
				ADDR_STATUS: begin
					rdata_d[ST_AVAIL_BIT] = avail_q;
					rdata_d[ST_FERR_BIT] = ferr_q;
					rdata_d[ST_PERR_BIT] = perr_q;
					rdata_d[ST_OVR_BIT] = ovr_q;
					rdata_d[ST_NINTH_BIT] = buf_q[8];
				end
				ADDR_DATA: rdata_d[DATA_W-1:0] = buf_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			buf_q <= '0;
			ferr_q <= 1'b0;
			perr_q <= 1'b0;
			ovr_q <= 1'b0;
			avail_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			size_q <= 3'h3;
		end else begin
			buf_q <= buf_d;
			ferr_q <= ferr_d;
			perr_q <= perr_d;
			ovr_q <= ovr_d;
			avail_q <= avail_d;
			rdata_q <= rdata_d;
			size_q <= size;
		end
	end

	assign rdata_out = rdata_q;
	// One size setting serves both directions; filter never reaches transmit.
	assign char_size_field_out = size_q;
endmodule

// *** urfr_pkg.sv ***
// Package of constants and types for the serial receive frame recovery block.
package urfr_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_DATA = 4'h8;
	// Control fields.
	localparam int CTRL_RX_EN_BIT = 0;
	localparam int CTRL_DOUBLE_BIT = 1;
	localparam int CTRL_MPCM_BIT = 2;
	localparam int CTRL_SIZE_LSB = 4;
	localparam int CTRL_PAR_EN_BIT = 8;
	localparam int CTRL_PAR_ODD_BIT = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
	// Status fields.
	localparam int ST_AVAIL_BIT = 0;
	localparam int ST_FERR_BIT = 1;
	localparam int ST_PERR_BIT = 2;
	localparam int ST_OVR_BIT = 3;
	localparam int ST_NINTH_BIT = 4;
	// Data register width and character size codes.
	localparam int DATA_W = 9;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	// ---------------------------------------------------------------
	// Sampling figures
	// ---------------------------------------------------------------
	localparam logic [4:0] SPB_NORMAL = 5'h10;
	localparam logic [4:0] SPB_DOUBLE = 5'h08;
	localparam logic [4:0] FIRST_NORMAL = 5'h08;
	localparam logic [4:0] FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] MID_NORMAL = 5'h09;
	localparam logic [4:0] MID_DOUBLE = 5'h05;
	localparam logic [4:0] LAST_NORMAL = 5'h0A;
	localparam logic [4:0] LAST_DOUBLE = 5'h06;
	// In double speed the next start is taken only from this stop sample on.
	localparam logic [4:0] REARM_DOUBLE = 5'h08;
	// Sample tick divisor at 16x rate, in system clocks.
	localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
	typedef enum logic [1:0] {URFR_IDLE, URFR_START, URFR_BITS, URFR_STOP} urfr_state_t;
endpackage

// *** urfr_chk.sv ***
// Checker for the register port of the serial receive block.
module urfr_chk
	import urfr_pkg::*;
(
	input wire logic clk_sys_in, // clock
	input wire logic rst_b_in, // reset
	input wire logic rxd_in, // line
	input wire logic [3:0] addr_in, // address
	input wire logic [31:0] wdata_in, // wdata
	input wire logic wr_in, // write
	input wire logic rd_in, // read
	input wire logic [15:0] baud_divisor_in, // divisor
	input wire logic [31:0] rdata_out, // rdata
	input wire logic [2:0] char_size_field_out // size
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	AST_IDLE_ZERO:
		assert property (!rd_in |=> rdata_out == 32'h0000_0000) else $error("idle read data");
	AST_UNMAPPED_ZERO:
		assert property (rd_in && addr_in[1:0] != 2'h0 |=> rdata_out == 32'h0000_0000) else $error("unmapped");
	AST_DATA_WIDTH:
		assert property (rd_in && addr_in == ADDR_DATA |=> rdata_out[31:9] == 23'h00_0000) else $error("data width");
	AST_STATUS_WIDTH:
		assert property (rd_in && addr_in == ADDR_STATUS |=> rdata_out[31:5] == 27'h000_0000) else $error("status");
	AST_SIZE_FOLLOW:
		assert property (wr_in && addr_in == ADDR_CTRL |-> ##2 char_size_field_out == $past(wdata_in[6:4], 2))
			else $error("size follow");
	AST_SIZE_HOLD:
		assert property ($changed(char_size_field_out) |-> $past(wr_in && addr_in == ADDR_CTRL, 2)) else $error("size hold");
	AST_SIZE_READBACK:
		assert property (rd_in && addr_in == ADDR_CTRL |=> rdata_out[6:4] == char_size_field_out) else $error("readback");
	AST_AVAIL_CLEARS:
		assert property (rd_in && addr_in == ADDR_DATA ##2 rd_in && addr_in == ADDR_STATUS |=> !rdata_out[ST_AVAIL_BIT])
			else $error("avail kept");
	cover property (rd_in && addr_in == ADDR_STATUS ##1 rdata_out[ST_FERR_BIT]);
	cover property (rd_in && addr_in == ADDR_STATUS ##1 rdata_out[ST_NINTH_BIT]);
	cover property (wr_in && addr_in == ADDR_CTRL);
endmodule
bind urfr_top urfr_chk urfr_chk_i (.clk_sys_in, .rst_b_in, .rxd_in, .addr_in, .wdata_in, .wr_in, .rd_in,
	.baud_divisor_in, .rdata_out, .char_size_field_out);

// *** urfr_tx_model.sv ***
// Remote serial transmitter model driving the receive line.
module urfr_tx_model (
	input wire logic clk_in, // clock
	input wire logic go_in, // start pulse
	input wire logic [9:0] bits_in, // frame, bit 0 first
	input wire logic [9:0] bits2_in, // frame sent right after
	input wire logic [3:0] nb_in, // data plus parity
	input wire logic [4:0] cpb_in, // clocks per bit
	input wire logic stop_lvl_in, // first stop level
	input wire logic [4:0] stop_len_in, // first stop clocks
	input wire logic two_in, // second stop bit
	input wire logic again_in, // send second frame
	output logic txd_out, // line, idle high
	output logic busy_out // sending
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		txd_out = 1'b1;
		busy_out = 1'b0;
	end
	// ----------------------------------------------------------------
	// Frame shifter
	// ----------------------------------------------------------------
	task automatic frame(input logic [9:0] b, input logic s, input logic [4:0] len);
		txd_out <= 1'b0;
		repeat (cpb_in) @(posedge clk_in);
		for (int i = 0; i < nb_in; i++) begin
			txd_out <= b[i];
			repeat (cpb_in) @(posedge clk_in);
		end
		txd_out <= s;
		repeat (len) @(posedge clk_in);
		if (two_in) begin
			txd_out <= 1'b1;
			repeat (cpb_in) @(posedge clk_in);
		end
	endtask
	always @(posedge clk_in) begin
		if (go_in && !busy_out) begin
			busy_out <= 1'b1;
			frame(bits_in, stop_lvl_in, stop_len_in);
			if (again_in) begin
				frame(bits2_in, 1'b1, cpb_in);
			end
			txd_out <= 1'b1;
			busy_out <= 1'b0;
		end
	end
endmodule

// *** test_urfr_top.sv ***
// Self-checking testbench for the serial receive block.
module test_urfr_top
	import urfr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, go = 1'b0, two = 1'b0, again = 1'b0, sv = 1'b1;
	logic [3:0] addr_in = 4'h0, nb = 4'h8;
	logic [31:0] wdata_in = 32'h0000_0000, rdata_out, got;
	logic [9:0] b1 = 10'h000, b2 = 10'h000;
	logic [4:0] cpb = 5'h10, sl = 5'h10;
	logic [2:0] char_size_field_out;
	logic txd, busy;
	int failures = 0, total_checks = 0, cycles = 0;
	always #25 clk_sys_in = ~clk_sys_in;
	urfr_top urfr_top_i (.clk_sys_in, .rst_b_in, .rxd_in(txd), .addr_in, .wdata_in, .wr_in, .rd_in,
		.baud_divisor_in(16'h0000), .rdata_out, .char_size_field_out);
	urfr_tx_model urfr_tx_model_i (.clk_in(clk_sys_in), .go_in(go), .bits_in(b1), .bits2_in(b2), .nb_in(nb),
		.cpb_in(cpb), .stop_lvl_in(sv), .stop_len_in(sl), .two_in(two), .again_in(again), .txd_out(txd),
		.busy_out(busy));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		if (failures == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr_t(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd_t(input logic [3:0] a);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 got = rdata_out;
	endtask
	task automatic send(input logic [9:0] x, y, input logic [3:0] n, input logic d, s, input logic [4:0] l,
		input logic t, ag);
		@(posedge clk_sys_in);
		{b1, b2, nb, sv, sl, two, again, go} <= {x, y, n, s, l, t, ag, 1'b1};
		cpb <= d ? 5'h08 : 5'h10;
		@(posedge clk_sys_in);
		go <= 1'b0;
		#1;
		for (int k = 0; k < 3000 && busy === 1'b1; k++) begin
			@(posedge clk_sys_in);
			#1;
		end
		repeat (24) @(posedge clk_sys_in);
	endtask
	task automatic rx_chk(input logic [8:0] d, input logic fe, nine, input logic [31:0] m);
		rd_t(ADDR_STATUS);
		chk("status", {27'h000_0000, nine, 2'b00, fe, 1'b1} & m, got & m);
		rd_t(ADDR_DATA);
		chk("data", {23'h00_0000, d}, got);
		rd_t(ADDR_STATUS);
		chk("avail", 32'h0000_0000, got & 32'h0000_0001);
	endtask
	function automatic logic [9:0] mk(input logic [8:0] d, input int n, input logic p);
		mk = {1'b0, d} & ((10'h001 << n) - 10'h001);
		if (p) mk[n] = ^mk;
	endfunction
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [9:0] f, e;
		logic [2:0] c;
		logic db;
		int n;
		void'($urandom(13765));
		repeat (4) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		rd_t(ADDR_CTRL);
		chk("ctrl", CTRL_RESET, got);
		chk("size", 32'h0000_0003, {29'h0000_0000, char_size_field_out});
		rd_t(4'h2);
		chk("unmapped", 32'h0000_0000, got);
		for (int s = 0; s < 10; s++) begin
			c = (s % 5 == 4) ? SIZE_NINE : 3'(s % 5);
			db = (s >= 5);
			n = (c == SIZE_NINE) ? 9 : 5 + int'(c);
			f = mk(9'($urandom), n, db);
			e = mk(f[8:0], n, 1'b0);
			wr_t(ADDR_CTRL, {22'h00_0000, 1'b0, db, 1'b0, c, 1'b0, 1'b0, db, 1'b1});
			@(posedge clk_sys_in);
			#1;
			chk("size", {29'h0000_0000, c}, {29'h0000_0000, char_size_field_out});
			send(f, f, 4'(n + int'(db)), db, 1'b1, db ? 5'h08 : 5'h10, 1'($urandom), 1'b0);
			rx_chk(e[8:0], 1'b0, e[8], c == SIZE_NINE ? 32'h0000_001F : 32'h0000_000F);
		end
		wr_t(ADDR_CTRL, 32'h0000_0031);
		e = mk(9'($urandom), 8, 1'b0);
		send(e, e, 4'h8, 1'b0, 1'b0, 5'h10, 1'b1, 1'b0);
		rx_chk(e[8:0], 1'b1, 1'b0, 32'h0000_000F);
		for (int s = 0; s < 2; s++) begin
			wr_t(ADDR_CTRL, 32'h0000_0075 | (32'(s) << CTRL_DOUBLE_BIT));
			f = {2'b00, 8'($urandom)};
			e = {2'b01, 8'($urandom)};
			send(f, e, 4'h9, 1'(s), 1'b1, s ? 5'h07 : 5'h0A, 1'b0, 1'b1);
			rx_chk(e[8:0], 1'b0, 1'b1, 32'h0000_001F);
		end
		wr_t(ADDR_CTRL, 32'h0000_0005);
		send(10'h015, 10'h00A, 4'h5, 1'b0, 1'b0, 5'h10, 1'b1, 1'b1);
		rx_chk(9'h00A, 1'b0, 1'b0, 32'h0000_000F);
		wr_t(ADDR_CTRL, 32'h0000_0071);
		f = {2'b00, 8'($urandom)};
		send(f, f, 4'h9, 1'b0, 1'b1, 5'h10, 1'b0, 1'b0);
		rx_chk(f[8:0], 1'b0, 1'b0, 32'h0000_001F);
		final_report();
	end
endmodule
